/* clt_core.sv */
// Counter core of a configurable length timer with period and compare flags
// What this block does
// - length_select picks 8, 10, 12 or 16 bits; max 0FFh to 0FFFFh.
// - Writes under a short length keep low bits, upper bits forced zero.
// - Counter steps up or down each divided clock edge; software reads and writes.
// - Counter write replaces the count at once, no timer edge needed.
// - Clear zeroes count, prescaler and the latched direction.
// - clock_source_select picks auxiliary, sub-main or one of two external clocks.
// - input_divider_select divides selected clock by 1, 2, 4 or 8.
// - Counter advances only with nonzero mode and an active clock.
// - Up or up/down: period zero stops; nonzero restarts upward from zero.
// - Mode 00 stop, 01 up, 10 continuous, 11 up/down.
// - Up mode counts zero to period then back to zero.
// - Entering up mode above the period restarts from zero at once.
// - Up mode: channel-0 flag at period, wrap flag on period-to-zero step.
// - Period change: count on to new period, or roll to zero if below.
// - Continuous mode wraps at max; channel 0 acts as plain compare.
// - Continuous mode: wrap flag on max-to-zero step.
// - Up/down counts up to period then down to zero, repeating.
// - Flags set only on real count steps, never on software writes.
// - Three or seven channels; each channel and wrap may raise interrupts.
// - Up/down: wrap flag on step from 0001h to 0000h.
// - Up/down with period above max behaves as continuous mode.
// - Direction is held while stopped; restart continues same way.
`timescale 1ns/1ps

module clt_core
  import clt_pkg::*;
#(
  parameter int CHANNELS = 7                    // Three or seven channels
) (
  input  wire logic                 clk,                 // System clock 125 MHz
  input  wire logic                 srst,                // Synchronous reset
  input  wire logic                 aux_clock,           // Auxiliary clock
  input  wire logic                 sub_main_clock,      // Sub-main clock
  input  wire logic                 timer_clock_in,      // External clock
  input  wire logic                 alt_ext_clock,       // Alternate external clock
  input  wire logic [1:0]           clock_source_select, // Clock source
  input  wire logic [1:0]           input_divider_select,// Divide by 1,2,4,8
  input  wire logic [1:0]           length_select,       // Counter length
  input  wire logic [1:0]           mode_control,        // Counting mode
  input  wire logic                 count_clear_bit,     // Clear pulse
  input  wire logic                 count_wr,            // Counter write strobe
  input  wire logic [15:0]          count_wdata,         // Counter write data
  input  wire logic [15:0]          period_latch,        // Channel 0 latch
  input  wire logic [CHANNELS-1:1]  compare_hit,         // Channel n equals count
  input  wire logic                 wrap_ie,             // Wrap interrupt enable
  input  wire logic [CHANNELS-1:0]  cmp_ie,              // Compare interrupt enables
  input  wire logic                 wrap_clr,            // Clear wrap flag
  input  wire logic [CHANNELS-1:0]  cmp_clr,             // Clear compare flags
  output logic [15:0]               count_value,         // Counter value
  output logic                      count_down,          // Direction, 1 = down
  output logic                      wrap_flag,           // Sticky wrap flag
  output logic [CHANNELS-1:0]       compare_event_flag,  // Sticky compare flags
  output logic                      irq                  // Interrupt request
);

  clt_state_t s_reg;
  clt_state_t s_next;

  logic [15:0] max_cnt;
  logic        src_lvl;
  logic        src_rise;
  logic        tick;
  logic [2:0]  div_mask;
  logic [15:0] period_m;
  logic [15:0] cnt_nx;
  logic        stepped;
  logic        wrap_ev;
  logic [CHANNELS-1:0] cmp_ev;

  // Maximum count per length
  always_comb begin
    if (length_select == CLT_LEN_8) begin
      max_cnt = CLT_MAX_8;
    end else if (length_select == CLT_LEN_10) begin
      max_cnt = CLT_MAX_10;
    end else if (length_select == CLT_LEN_12) begin
      max_cnt = CLT_MAX_12;
    end else begin
      max_cnt = CLT_MAX_16;
    end
  end

  // Source selection and divider mask
  always_comb begin
    case (clock_source_select)
      CLT_SRC_EXT: src_lvl = timer_clock_in;
      CLT_SRC_AUX: src_lvl = aux_clock;
      CLT_SRC_SUB: src_lvl = sub_main_clock;
      default:     src_lvl = alt_ext_clock;
    endcase
    case (input_divider_select)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  // Edge of the synchronised clock and prescaled tick
  assign src_rise = s_reg.src_meta[0] & ~s_reg.src_meta[1];
  assign tick     = src_rise && ((s_reg.div_cnt & div_mask) == div_mask);
  assign period_m = period_latch & max_cnt;

  // Next state
  always_comb begin
    s_next   = s_reg;
    cnt_nx   = s_reg.count;
    stepped  = 1'b0;
    wrap_ev  = 1'b0;
    cmp_ev   = '0;
    s_next.src_sync    = {s_reg.src_sync[1:0], src_lvl};
    s_next.src_meta    = {s_reg.src_meta[1:0], s_reg.src_sync[0]};
    s_next.prev_period = period_latch;

    // Period of zero halts; nonzero restarts upward from zero
    if (period_latch == 16'h0000) begin
      s_next.halted = 1'b1;
    end else if (s_reg.halted) begin
      s_next.halted = 1'b0;
      cnt_nx        = 16'h0000;
      s_next.down   = 1'b0;
    end

    if (src_rise) begin
      s_next.div_cnt = s_reg.div_cnt + 3'h1;
    end

    // Counting, only with nonzero mode and an active clock
    if (tick && mode_control != CLT_MODE_STOP) begin
      stepped = 1'b1;
      case (clt_mode_t'(mode_control))
        CLT_MODE_UP: begin
          if (s_reg.halted || period_latch == 16'h0000) begin
            stepped = 1'b0;
          end else if (s_reg.count >= period_m) begin
            cnt_nx = 16'h0000;
            wrap_ev = (s_reg.count == period_m);
          end else begin
            cnt_nx = s_reg.count + 16'h0001;
          end
        end
        CLT_MODE_CONT: begin
          if (s_reg.count >= max_cnt) begin
            cnt_nx  = 16'h0000;
            wrap_ev = 1'b1;
          end else begin
            cnt_nx = s_reg.count + 16'h0001;
          end
        end
        CLT_MODE_UPDN: begin
          if (s_reg.halted || period_latch == 16'h0000) begin
            stepped = 1'b0;
          end else if (period_latch > max_cnt) begin
            // Behaves as continuous, no descent from max
            s_next.down = 1'b0;
            if (s_reg.count >= max_cnt) begin
              cnt_nx  = 16'h0000;
              wrap_ev = 1'b1;
            end else begin
              cnt_nx = s_reg.count + 16'h0001;
            end
          end else if (s_reg.down) begin
            if (s_reg.count == 16'h0000) begin
              s_next.down = 1'b0;
              cnt_nx      = 16'h0001;
            end else begin
              cnt_nx  = s_reg.count - 16'h0001;
              wrap_ev = (s_reg.count == 16'h0001);
              s_next.down = (s_reg.count != 16'h0001);
            end
          end else if (s_reg.count >= period_m) begin
            s_next.down = 1'b1;
            cnt_nx      = s_reg.count - 16'h0001;
          end else begin
            cnt_nx = s_reg.count + 16'h0001;
          end
        end
        default: stepped = 1'b0;
      endcase
    end

    // Entering up mode above the period restarts at once
    // A zero period halts instead, so the held count survives
    if (mode_control == CLT_MODE_UP && s_reg.count > period_m && !stepped
        && period_latch != 16'h0000) begin
      cnt_nx = 16'h0000;
    end

    // Compare events only from real count steps
    if (stepped && cnt_nx != s_reg.count) begin
      cmp_ev[0] = (cnt_nx == period_m);
    end
    for (int i = 1; i < CHANNELS; i++) begin
      cmp_ev[i] = stepped && compare_hit[i];
    end
    if (!stepped) begin
      wrap_ev = 1'b0;
    end

    s_next.count = cnt_nx & max_cnt;

    // Software write replaces count at once
    if (count_wr) begin
      s_next.count = count_wdata & max_cnt;
    end

    // Clear zeroes count, prescaler and direction
    if (count_clear_bit) begin
      s_next.count   = CLT_COUNT_RST;
      s_next.div_cnt = CLT_DIV_RST;
      s_next.down    = 1'b0;
    end

    // Sticky flags, set wins over clear
    s_next.wrap_flag = (s_reg.wrap_flag & ~wrap_clr) | wrap_ev;
    s_next.cmp_flag  = '0;
    s_next.cmp_flag[CHANNELS-1:0] = (s_reg.cmp_flag[CHANNELS-1:0] & ~cmp_clr) | cmp_ev;
    s_next.irq = (s_next.wrap_flag & wrap_ie) |
                 (|(s_next.cmp_flag[CHANNELS-1:0] & cmp_ie));
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count_value        = s_reg.count;
  assign count_down         = s_reg.down;
  assign wrap_flag          = s_reg.wrap_flag;
  assign compare_event_flag = s_reg.cmp_flag[CHANNELS-1:0];
  assign irq                = s_reg.irq;

  // Helper tracking a real step for assertions
  logic was_step;
  always_ff @(posedge clk) begin
    if (srst) begin
      was_step <= 1'b0;
    end else begin
      was_step <= stepped;
    end
  end

  sequence s_cont_wrap;
    mode_control == CLT_MODE_CONT && tick && s_reg.count == max_cnt && !count_wr && !count_clear_bit;
  endsequence

  property p_len_bound;
    @(posedge clk) disable iff (srst) count_value <= max_cnt || $changed(length_select);
  endproperty
  a_len_bound: assert property (p_len_bound) else $error("count above length maximum");

  property p_write_now;
    @(posedge clk) disable iff (srst) count_wr && !count_clear_bit |=> count_value == ($past(count_wdata) & $past(max_cnt));
  endproperty
  a_write_now: assert property (p_write_now) else $error("counter write not applied");

  property p_clear;
    @(posedge clk) disable iff (srst) count_clear_bit |=> count_value == 16'h0000 && !count_down;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_stop_holds;
    @(posedge clk) disable iff (srst)
      mode_control == CLT_MODE_STOP && !count_wr && !count_clear_bit && period_latch != 16'h0000 && !s_reg.halted
      |=> $stable(count_value);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

  property p_cont_wrap;
    @(posedge clk) disable iff (srst) s_cont_wrap |=> count_value == 16'h0000 ##0 wrap_flag;
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) else $error("continuous wrap missing");

  property p_up_bound;
    @(posedge clk) disable iff (srst)
      mode_control == CLT_MODE_UP && !count_wr && $past(mode_control) == CLT_MODE_UP && period_latch != 16'h0000
      && $stable(period_latch) && $stable(length_select) |-> count_value <= (period_latch & max_cnt);
  endproperty
  a_up_bound: assert property (p_up_bound) else $error("up mode exceeded period");

  property p_wrap_sticky;
    @(posedge clk) disable iff (srst) wrap_flag && !wrap_clr |=> wrap_flag;
  endproperty
  a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap flag lost");

  property p_wrap_cause;
    @(posedge clk) disable iff (srst) $rose(wrap_flag) |-> was_step;
  endproperty
  a_wrap_cause: assert property (p_wrap_cause) else $error("wrap flag without count step");

  property p_updn_wrap;
    @(posedge clk) disable iff (srst)
      mode_control == CLT_MODE_UPDN && tick && s_reg.down && s_reg.count == 16'h0001
      && !count_wr && !count_clear_bit && period_latch != 16'h0000 && !s_reg.halted && period_latch <= max_cnt
      |=> count_value == 16'h0000 && wrap_flag;
  endproperty
  a_updn_wrap: assert property (p_updn_wrap) else $error("up/down wrap missing");

  // Zero period in up or up/down mode holds the count
  sequence s_halted_cfg;
    (mode_control == CLT_MODE_UP || mode_control == CLT_MODE_UPDN) && period_latch == 16'h0000
    && $stable(length_select) && !count_wr && !count_clear_bit;
  endsequence
  property p_halt_hold;
    @(posedge clk) disable iff (srst) s_halted_cfg |=> $stable(count_value);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counter moved with zero period");

  // Nonzero period after a halt restarts upward from zero
  sequence s_restart;
    s_reg.halted && period_latch != 16'h0000 && mode_control != CLT_MODE_CONT && !count_wr && !count_clear_bit;
  endsequence
  property p_restart;
    @(posedge clk) disable iff (srst) s_restart |=> count_value == 16'h0000 && !count_down;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not from zero upward");

  // Up mode step onto the period raises the channel-0 flag
  sequence s_up_reach;
    mode_control == CLT_MODE_UP && tick && !s_reg.halted && period_latch != 16'h0000 && period_latch <= max_cnt
    && s_reg.count + 16'h0001 == period_m && !count_wr && !count_clear_bit;
  endsequence
  property p_up_reach;
    @(posedge clk) disable iff (srst) s_up_reach |=> compare_event_flag[0];
  endproperty
  a_up_reach: assert property (p_up_reach) else $error("period flag missing in up mode");

  // Up/down turns at the period and steps down
  sequence s_updn_top;
    mode_control == CLT_MODE_UPDN && tick && !s_reg.down && s_reg.count == period_m && !s_reg.halted
    && period_latch != 16'h0000 && period_latch <= max_cnt && !count_wr && !count_clear_bit;
  endsequence
  property p_updn_turn;
    @(posedge clk) disable iff (srst) s_updn_top |=> count_down && count_value == $past(count_value) - 16'h0001;
  endproperty
  a_updn_turn: assert property (p_updn_turn) else $error("up/down turn missing");

  // Interrupt follows flags and enables
  property p_irq_follow;
    @(posedge clk) disable iff (srst)
      1'b1 |=> irq == ((wrap_flag && $past(wrap_ie)) || (|(compare_event_flag & $past(cmp_ie))));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt does not follow flags");

endmodule // clt_core

/* clt_pkg.sv */
// Constants and types shared by the configurable length timer core
package clt_pkg;

  // Counter length selections
  localparam logic [1:0] CLT_LEN_8  = 2'h0;
  localparam logic [1:0] CLT_LEN_10 = 2'h1;
  localparam logic [1:0] CLT_LEN_12 = 2'h2;
  localparam logic [1:0] CLT_LEN_16 = 2'h3;

  // Maximum counts per length
  localparam logic [15:0] CLT_MAX_8  = 16'h00FF;
  localparam logic [15:0] CLT_MAX_10 = 16'h03FF;
  localparam logic [15:0] CLT_MAX_12 = 16'h0FFF;
  localparam logic [15:0] CLT_MAX_16 = 16'hFFFF;

  // Clock source selections
  localparam logic [1:0] CLT_SRC_EXT  = 2'h0;
  localparam logic [1:0] CLT_SRC_AUX  = 2'h1;
  localparam logic [1:0] CLT_SRC_SUB  = 2'h2;
  localparam logic [1:0] CLT_SRC_ALT  = 2'h3;

  // Reset values
  localparam logic [15:0] CLT_COUNT_RST = 16'h0000;
  localparam logic [2:0]  CLT_DIV_RST   = 3'h0;

  // Counting modes
  typedef enum logic [1:0] {
    CLT_MODE_STOP = 2'b00,
    CLT_MODE_UP   = 2'b01,
    CLT_MODE_CONT = 2'b10,
    CLT_MODE_UPDN = 2'b11
  } clt_mode_t;

  // Complete core state
  typedef struct packed {
    logic [2:0]  src_sync;     // Selected clock, stage one
    logic [2:0]  src_meta;     // Selected clock, stage two and history
    logic [2:0]  div_cnt;      // Prescaler
    logic [15:0] count;        // Counter value
    logic        down;         // Latched direction
    logic        halted;       // Period of zero stopped counting
    logic [15:0] prev_period;  // Period on the last cycle
    logic        wrap_flag;    // Sticky wrap flag
    logic [6:0]  cmp_flag;     // Sticky compare flags
    logic        irq;          // Combined interrupt request
  } clt_state_t;

endpackage : clt_pkg

/* tb_clt_core.sv */
// Self-checking testbench for the configurable length timer core
`timescale 1ns/1ps

module tb_clt_core;
  import clt_pkg::*;

  typedef struct {
    int          sel;
    string       name;
    logic [15:0] exp;
  } clt_note_t;

  localparam int CH = 3;
  logic          clk;
  logic          srst;
  logic [3:0]    src_pins;   // Indexed by clock source code
  logic [1:0]    src_sel;
  logic [1:0]    div_sel;
  logic [1:0]    len_sel;
  logic [1:0]    mode;
  logic          clr;
  logic          wr;
  logic          wrap_ie;
  logic          wrap_clr;
  logic [15:0]   wdata;
  logic [15:0]   period;
  logic [CH-1:1] hit;
  logic [CH-1:0] cmp_ie;
  logic [CH-1:0] cmp_clr;
  logic [15:0]   count_value;
  logic          count_down;
  logic          wrap_flag;
  logic          irq;
  logic [CH-1:0] compare_event_flag;
  logic [15:0]   maxes [4];
  logic [31:0]   r;
  int            fails;
  int            cmp_count;
  clt_note_t     notes[$];
  event          chk_ev;

  clt_core #(.CHANNELS(CH)) u_dut (
    .clk(clk), .srst(srst), .aux_clock(src_pins[1]), .sub_main_clock(src_pins[2]),
    .timer_clock_in(src_pins[0]), .alt_ext_clock(src_pins[3]), .clock_source_select(src_sel),
    .input_divider_select(div_sel), .length_select(len_sel), .mode_control(mode),
    .count_clear_bit(clr), .count_wr(wr), .count_wdata(wdata), .period_latch(period),
    .compare_hit(hit), .wrap_ie(wrap_ie), .cmp_ie(cmp_ie), .wrap_clr(wrap_clr), .cmp_clr(cmp_clr),
    .count_value(count_value), .count_down(count_down), .wrap_flag(wrap_flag),
    .compare_event_flag(compare_event_flag), .irq(irq));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Queue an expectation for the output monitor
  task automatic note(input int sel, input string name, input logic [15:0] exp);
    clt_note_t n;
    n.sel = sel;
    n.name = name;
    n.exp = exp;
    notes.push_back(n);
    -> chk_ev;
  endtask

  // Source clock pulses, each long enough for the synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      src_pins[src_sel] = 1'b1;
      cyc(3);
      src_pins[src_sel] = 1'b0;
      cyc(5);
    end
  endtask

  task automatic write_cnt(input logic [15:0] v);
    wr = 1'b1;
    wdata = v;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic clear_cnt();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
  endtask

  task automatic clr_flags();
    wrap_clr = 1'b1;
    cmp_clr = '1;
    cyc(1);
    wrap_clr = 1'b0;
    cmp_clr = '0;
    cyc(1);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Output monitor: pops every queued note, oldest first, and compares
  initial begin
    clt_note_t   n;
    logic [15:0] obs;
    forever begin
      @(chk_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.sel)
          0: obs = count_value;
          1: obs = {15'h0000, wrap_flag};
          2: obs = {13'h0000, compare_event_flag};
          3: obs = {15'h0000, count_down};
          default: obs = {15'h0000, irq};
        endcase
        cmp_count++;
        if (obs !== n.exp) begin
          fails++;
          $display("[ERR] %s expected %h seen %h", n.name, n.exp, obs);
        end
      end
    end
  end

  // Watchdog
  initial begin
    cyc(20000);
    fails++;
    $display("[ERR] watchdog expected end seen timeout");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    maxes = '{CLT_MAX_8, CLT_MAX_10, CLT_MAX_12, CLT_MAX_16};
    srst = 1'b1; src_pins = 4'h0; src_sel = 2'h0; div_sel = 2'h0; len_sel = CLT_LEN_16;
    mode = CLT_MODE_STOP; clr = 1'b0; wr = 1'b0; wrap_ie = 1'b0; wrap_clr = 1'b0;
    wdata = 16'h0000; period = 16'h0000; hit = '0; cmp_ie = '0; cmp_clr = '0;
    void'($urandom(14));
    cyc(16);
    srst = 1'b0;
    cyc(1);
    note(0, "reset count", 16'h0000);
    note(1, "reset wrap", 16'h0000);
    $display("test reset done");
    // Lengths, masking, wrap at each maximum, interrupt enable
    for (int l = 0; l < 4; l++) begin
      len_sel = 2'(l);
      wrap_ie = l[0];
      r = $urandom();
      write_cnt(r[15:0]);
      note(0, "masked write", r[15:0] & maxes[l]);
      write_cnt(maxes[l]);
      note(0, "max write", maxes[l]);
      note(1, "wrap after write", 16'h0000);
      mode = CLT_MODE_CONT;
      tick(1);
      note(0, "wrap count", 16'h0000);
      note(1, "wrap flag", 16'h0001);
      note(4, "irq", {15'h0000, l[0]});
      mode = CLT_MODE_STOP;
      clr_flags();
    end
    $display("test lengths done");
    // Every source and divider, then stop mode
    period = 16'h0100;
    mode = CLT_MODE_CONT;
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        src_sel = 2'(s);
        div_sel = 2'(d);
        clear_cnt();
        tick((1 << d) - 1);
        note(0, "divider hold", 16'h0000);
        tick(1);
        note(0, "divider step", 16'h0001);
      end
    end
    div_sel = 2'h0;
    cmp_ie = 3'h2;
    hit = 2'h1;
    tick(1);
    hit = 2'h0;
    note(2, "channel one flag", 16'h0002);
    note(4, "irq compare", 16'h0001);
    mode = CLT_MODE_STOP;
    tick(2);
    note(0, "stopped count", 16'h0002);
    $display("test sources done");
    // Up mode
    src_sel = 2'h0; div_sel = 2'h0; cmp_ie = '0;
    clear_cnt();
    clr_flags();
    period = 16'h0003;
    mode = CLT_MODE_UP;
    write_cnt(16'h0003);
    note(2, "flag on write", 16'h0000);
    tick(1);
    note(0, "up roll", 16'h0000);
    note(1, "up wrap", 16'h0001);
    clr_flags();
    tick(3);
    note(0, "up top", 16'h0003);
    note(2, "period flag", 16'h0001);
    note(1, "no wrap", 16'h0000);
    mode = CLT_MODE_STOP;
    write_cnt(16'h0009);
    mode = CLT_MODE_UP;
    cyc(3);
    note(0, "up above period", 16'h0000);
    tick(2);
    period = 16'h0000;
    tick(2);
    note(0, "period zero halt", 16'h0002);
    period = 16'h0005;
    tick(1);
    note(0, "restart from zero", 16'h0001);
    period = 16'h0008;
    tick(3);
    note(0, "new larger period", 16'h0004);
    $display("test up done");
    // Up/down mode, held direction, clear of direction
    mode = CLT_MODE_STOP;
    clear_cnt();
    clr_flags();
    period = 16'h0002;
    mode = CLT_MODE_UPDN;
    tick(2);
    note(2, "updn period flag", 16'h0001);
    tick(1);
    note(0, "down step", 16'h0001);
    note(3, "down dir", 16'h0001);
    mode = CLT_MODE_STOP;
    tick(2);
    mode = CLT_MODE_UPDN;
    tick(1);
    note(0, "down to zero", 16'h0000);
    note(1, "updn wrap", 16'h0001);
    tick(3);
    clear_cnt();
    note(0, "clear count", 16'h0000);
    note(3, "clear dir", 16'h0000);
    tick(1);
    note(0, "up after clear", 16'h0001);
    clr_flags();
    len_sel = CLT_LEN_8;
    period = 16'h01FF;
    write_cnt(16'h00FF);
    tick(1);
    note(0, "large period wrap", 16'h0000);
    note(1, "large period flag", 16'h0001);
    $display("test updown done");
    cyc(2);
    tally_and_finish();
  end
endmodule // tb_clt_core
